// ---- pcft_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcft_top #(
  parameter int unsigned HALF_1K = pcft_pkg::HALF_1K,
  parameter int unsigned HALF_200 = pcft_pkg::HALF_200,
  parameter int unsigned HALF_10 = pcft_pkg::HALF_10,
  parameter int unsigned HALF_4 = pcft_pkg::HALF_4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Interval select
  input wire logic carry_interval_sel_hi,
  input wire logic carry_interval_sel_lo,
  // Flag read
  input wire logic register_read_instruction,
  output logic read_valid,
  output logic read_data,
  // Chip enable
  input wire logic ce_pin,
  output logic ce_reset,
  // Status
  output pcft_pkg::pcft_status_t status
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Interval pulses
  // ----------------------------------------------------------------
  localparam int unsigned HALVES [pcft_pkg::NUM_PULSES] = '{HALF_1K, HALF_200, HALF_10, HALF_4};
  logic [pcft_pkg::NUM_PULSES-1:0] pulses;

  for (genvar i = 0; i < pcft_pkg::NUM_PULSES; i++) begin : g_div
    pcft_divider #(.HALF(HALVES[i])) u_div (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pulse(pulses[i])
    );
  end

  function automatic logic [1:0] sel_index(input logic [1:0] sel);
    logic [1:0] idx;
    idx = pcft_pkg::IDX_10;
    unique case (sel)
      pcft_pkg::SEL_1K: idx = pcft_pkg::IDX_1K;
      pcft_pkg::SEL_200: idx = pcft_pkg::IDX_200;
      pcft_pkg::SEL_4: idx = pcft_pkg::IDX_4;
      pcft_pkg::SEL_10: idx = pcft_pkg::IDX_10;
    endcase
    return idx;
  endfunction : sel_index

  logic [1:0] sel;
  logic sel_pulse;
  assign sel = {carry_interval_sel_hi, carry_interval_sel_lo};
  assign sel_pulse = pulses[sel_index(sel)];

  // ----------------------------------------------------------------
  // Carry flag and chip-enable reset
  // ----------------------------------------------------------------
  logic sel_pulse_q;
  logic ce_q;
  logic armed;
  logic flag;
  logic pending;
  logic next_sel_pulse_q;
  logic next_ce_q;
  logic next_armed;
  logic next_flag;
  logic next_pending;
  logic next_read_valid;
  logic next_read_data;
  logic next_ce_reset;
  logic rise;
  logic ce_rise;
  logic ce_fire;

  // Rise compares against the previously observed level, so a switch from a low pulse to a high one counts as a rise
  assign rise = sel_pulse & ~sel_pulse_q;
  assign ce_rise = ce_pin & ~ce_q;
  assign ce_fire = rise & pending & ~register_read_instruction;

  always_comb begin
    next_sel_pulse_q = sel_pulse;
    next_ce_q = ce_pin;
    next_armed = armed | register_read_instruction | ce_fire;
    next_read_valid = register_read_instruction;
    next_read_data = register_read_instruction ? flag : read_data;
    next_ce_reset = ce_fire;
    next_flag = flag;
    if (register_read_instruction) begin
      next_flag = 1'b0;
    end
    if (rise && armed) begin
      next_flag = 1'b1;
    end
    if (ce_fire) begin
      next_flag = 1'b1;
    end
    next_pending = pending;
    if (ce_fire) begin
      next_pending = 1'b0;
    end
    if (ce_rise) begin
      next_pending = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_pulse_q <= 1'b0;
      ce_q <= 1'b0;
      armed <= 1'b0;
      flag <= 1'b0;
      pending <= 1'b0;
      read_valid <= 1'b0;
      read_data <= 1'b0;
      ce_reset <= 1'b0;
    end else begin
      sel_pulse_q <= next_sel_pulse_q;
      ce_q <= next_ce_q;
      armed <= next_armed;
      flag <= next_flag;
      pending <= next_pending;
      read_valid <= next_read_valid;
      read_data <= next_read_data;
      ce_reset <= next_ce_reset;
    end
  end

  assign status = '{carry_event_flag: flag, ce_pending: pending};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_read_clears: assert property (register_read_instruction && !rise |=> !flag)
    else $error("flag not cleared by read");
  a_read_returns: assert property (register_read_instruction |=> read_valid && read_data == $past(flag))
    else $error("read data wrong");
  a_set_on_rise: assert property (rise && armed |=> flag)
    else $error("flag not set on rise");
  a_unarmed_quiet: assert property (!armed && !ce_fire |=> !flag)
    else $error("flag set before first read");
  a_ce_sets_flag: assert property (ce_fire |=> flag && ce_reset ##1 !ce_reset)
    else $error("chip-enable reset wrong");
  a_read_wins: assert property (rise && pending && register_read_instruction && !ce_rise
    |=> !ce_reset && pending)
    else $error("read did not win over reset");
  a_ce_waits: assert property (!rise |=> !ce_reset)
    else $error("reset issued without pulse rise");
  a_pending_clear: assert property (ce_fire && !ce_rise |=> !pending)
    else $error("pending not cleared");
  a_switch_hold: assert property ($changed(sel) && !sel_pulse && !register_read_instruction && !ce_fire
    |=> flag == $past(flag))
    else $error("flag changed on switch to low pulse");

  c_first_read: cover property (!armed ##1 register_read_instruction ##[1:1000] rise);
  c_ce_reset: cover property (ce_rise ##[1:1000] ce_reset);
  c_collision: cover property (rise && pending && register_read_instruction);
  c_switch_rise: cover property ($changed(sel) && rise);
endmodule : pcft_top
`default_nettype wire

// ---- pcft_pkg.sv ----
package pcft_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PER_1K_NS = 1000000;
  localparam int unsigned PER_200_NS = 5000000;
  localparam int unsigned PER_10_NS = 100000000;
  localparam int unsigned PER_4_NS = 250000000;
  localparam int unsigned HALF_1K = PER_1K_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned HALF_200 = PER_200_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned HALF_10 = PER_10_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned HALF_4 = PER_4_NS / (2 * CLK_PERIOD_NS);
  // ----------------------------------------------------------------
  // Pulse indices and select encoding
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PULSES = 4;
  localparam logic [1:0] IDX_1K = 2'h0;
  localparam logic [1:0] IDX_200 = 2'h1;
  localparam logic [1:0] IDX_10 = 2'h2;
  localparam logic [1:0] IDX_4 = 2'h3;
  localparam logic [1:0] SEL_1K = 2'h3;
  localparam logic [1:0] SEL_200 = 2'h2;
  localparam logic [1:0] SEL_4 = 2'h1;
  localparam logic [1:0] SEL_10 = 2'h0;
  // ----------------------------------------------------------------
  // Status carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic carry_event_flag;
    logic ce_pending;
  } pcft_status_t;
endpackage : pcft_pkg

// ---- pcft_divider.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcft_divider #(
  parameter int unsigned HALF = 500
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Square wave out
  output logic pulse
);
  localparam int W = $clog2(HALF + 1);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_pulse;

  // Free-running half-period counter; only rst_n can restart it
  always_comb begin
    next_cnt = cnt + W'(1);
    next_pulse = pulse;
    if (cnt == W'(HALF - 1)) begin
      next_cnt = '0;
      next_pulse = ~pulse;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      pulse <= 1'b0;
    end else begin
      cnt <= next_cnt;
      pulse <= next_pulse;
    end
  end
endmodule : pcft_divider
`default_nettype wire

// ---- pcft_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcft_cpu_model #(
  parameter int POLL = 7
) (
  // Clock and enable
  input wire logic core_clk,
  input wire logic poll_en,
  // Flag read
  output logic rd,
  input wire logic read_valid,
  input wire logic read_data,
  // Flags seen
  output int hits
);
  int cnt = 0;
  initial begin
    rd = 1'b0;
    hits = 0;
  end
  // Poll well inside the carry interval, no update time
  always @(posedge core_clk) begin
    cnt <= (!poll_en || cnt == POLL - 1) ? 0 : cnt + 1;
    rd <= poll_en && cnt == POLL - 1;
    if (poll_en && read_valid === 1'b1 && read_data === 1'b1) begin
      hits <= hits + 1;
    end
  end
endmodule : pcft_cpu_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0, rstn = 1'b0, hi = 1'b1, lo = 1'b1, tb_rd = 1'b0, ce = 1'b0, poll_en = 1'b0;
  logic cpu_rd, read_valid, read_data, ce_reset, v;
  pcft_pkg::pcft_status_t status;
  int err_count = 0, n_checks = 0, cyc = 0, hits, t0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end
  pcft_top #(.HALF_1K(5), .HALF_200(25), .HALF_10(500), .HALF_4(1250)) i_dut (.core_clk(core_clk),
    .rstn(rstn), .carry_interval_sel_hi(hi), .carry_interval_sel_lo(lo),
    .register_read_instruction(tb_rd | cpu_rd), .read_valid(read_valid), .read_data(read_data),
    .ce_pin(ce), .ce_reset(ce_reset), .status(status));
  pcft_cpu_model #(.POLL(7)) i_cpu (.core_clk(core_clk), .poll_en(poll_en), .rd(cpu_rd),
    .read_valid(read_valid), .read_data(read_data), .hits(hits));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic rd_flag(output logic d);
    @(posedge core_clk);
    tb_rd <= 1'b1;
    @(posedge core_clk);
    tb_rd <= 1'b0;
    tick(0);
    for (int i = 0; i < 3 && read_valid !== 1'b1; i++) tick(1);
    check(read_valid, 1'b1);
    d = read_data;
  endtask : rd_flag
  task automatic wait_flag(input int lim);
    for (int i = 0; i < lim && status.carry_event_flag !== 1'b1; i++) tick(1);
    check(status.carry_event_flag, 1'b1);
  endtask : wait_flag
  task automatic period(input logic [1:0] s, input int p);
    @(posedge core_clk);
    {hi, lo} <= s;
    wait_flag(p + 4);
    rd_flag(v);
    wait_flag(p + 4);
    t0 = cyc;
    rd_flag(v);
    wait_flag(p + 4);
    check(cyc - t0, p);
  endtask : period
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    tick(14);
    check(status.carry_event_flag, 1'b0);
    rd_flag(v);
    check(v, 1'b0);
    period(pcft_pkg::SEL_1K, 10);
    period(pcft_pkg::SEL_4, 2500);
    period(pcft_pkg::SEL_10, 1000);
    period(pcft_pkg::SEL_200, 50);
    // Switch while the new pulse is low, then back while it is high
    rd_flag(v);
    tick(2);
    @(posedge core_clk);
    {hi, lo} <= pcft_pkg::SEL_1K;
    tick(2);
    check(status.carry_event_flag, 1'b0);
    @(posedge core_clk);
    {hi, lo} <= pcft_pkg::SEL_200;
    tick(2);
    check(status.carry_event_flag, 1'b1);
    tick(110);
    rd_flag(v);
    check(v, 1'b1);
    rd_flag(v);
    check(v, 1'b0);
    // Reads every cycle block the pending chip-enable reset
    @(posedge core_clk);
    {hi, lo} <= pcft_pkg::SEL_1K;
    tb_rd <= 1'b1;
    ce <= 1'b1;
    tick(3);
    check(status.ce_pending, 1'b1);
    for (int i = 0; i < 25; i++) begin
      tick(1);
      check(ce_reset, 1'b0);
    end
    @(posedge core_clk);
    tb_rd <= 1'b0;
    tick(0);
    for (int i = 0; i < 13 && ce_reset !== 1'b1; i++) tick(1);
    check(ce_reset, 1'b1);
    check(status.carry_event_flag, 1'b1);
    check(status.ce_pending, 1'b0);
    tick(1);
    check(ce_reset, 1'b0);
    rd_flag(v);
    check(v, 1'b1);
    @(posedge core_clk);
    ce <= 1'b0;
    poll_en <= 1'b1;
    repeat (100) @(posedge core_clk);
    poll_en <= 1'b0;
    tick(0);
    check(hits >= 9 && hits <= 11, 1'b1);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
